// ---- rda_pkg.sv ----
package rda_pkg;
  // register addresses on the 4-bit register port
  localparam logic [3:0] RDA_ADDR_WEEKLY_MIN  = 4'h8;
  localparam logic [3:0] RDA_ADDR_WEEKLY_HOUR = 4'h9;
  localparam logic [3:0] RDA_ADDR_WEEKLY_DAYS = 4'ha;
  localparam logic [3:0] RDA_ADDR_DAILY_MIN   = 4'hb;
  localparam logic [3:0] RDA_ADDR_DAILY_HOUR  = 4'hc;
  // implemented field widths
  localparam int RDA_MIN_W  = 7;
  localparam int RDA_HOUR_W = 6;
  localparam int RDA_DAYS_W = 7;
  localparam int RDA_DAY_W  = 3;
  // meridiem / hour tens bit position in the hour field
  localparam int RDA_HOUR_MERIDIEM_BIT = 5;
  // last valid weekday count before wrapping
  localparam logic [2:0] RDA_DAY_LAST = 3'h6;
  localparam logic [2:0] RDA_DAY_FIRST = 3'h0;
  // powerup preset contents are undefined; flops take this value
  localparam logic [7:0] RDA_PRESET_RST = 8'h00;
endpackage : rda_pkg

// ---- rda_alarm_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
// Contract
// - weekly minute preset at 8h, bits 6:0, bit 7 reads zero
// - weekly hour preset at 9h, bits 5:0, bits 7:6 read zero
// - weekly hour bit 5 is meridiem in 12-hour mode, tens otherwise
// - weekday enable mask at Ah, bits 6:0, bit 7 reads zero
// - mask bit n matches weekday counter value n, 0 to 6
// - an all-zero mask silences the weekly alarm
// - 12-hour midnight is 12, noon is 32, written and compared
// - daily minute preset at Bh, bits 6:0, bit 7 reads zero
// - daily hour preset at Ch, bits 5:0, bits 7:6 read zero
// - daily hour bit 5 is meridiem in 12-hour mode, tens otherwise
// - after power-on presets undefined, unused high bits read zero
// - weekday counter steps by one from 0 to 6 then wraps
module rda_alarm_regs (
  input  wire logic                      clk,          // 200 MHz clock
  input  wire logic                      rst_b,        // async active-low reset
  input  wire logic [3:0]                reg_addr,     // register address
  input  wire logic                      reg_wr,       // write strobe
  input  wire logic [7:0]                reg_wdata,    // write data
  output logic      [7:0]                reg_rdata,    // read data for reg_addr
  output logic                           reg_hit,      // reg_addr is an alarm register
  input  wire logic [rda_pkg::RDA_MIN_W-1:0]  cur_min,  // current BCD minute
  input  wire logic [rda_pkg::RDA_HOUR_W-1:0] cur_hour, // current BCD hour, same coding as presets
  input  wire logic                      day_tick,     // one-cycle carry into next day
  input  wire logic                      day_wr,       // load weekday counter
  input  wire logic [rda_pkg::RDA_DAY_W-1:0]  day_wdata, // weekday load value
  output logic [rda_pkg::RDA_DAY_W-1:0]  day_count,    // weekday counter
  output logic                           weekly_match, // weekly alarm match level
  output logic                           daily_match   // daily alarm match level
);
  import rda_pkg::*;

  logic rst_meta_reg;
  logic rst_sync_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n_i = rst_sync_reg;

  logic [RDA_MIN_W-1:0]  wk_min_reg;
  logic [RDA_HOUR_W-1:0] wk_hour_reg;
  logic [RDA_DAYS_W-1:0] wk_days_reg;
  logic [RDA_MIN_W-1:0]  dy_min_reg;
  logic [RDA_HOUR_W-1:0] dy_hour_reg;
  logic [RDA_DAY_W-1:0]  day_reg;
  logic [RDA_DAY_W-1:0]  day_next;

  wire wr_wk_min  = reg_wr && (reg_addr == RDA_ADDR_WEEKLY_MIN);
  wire wr_wk_hour = reg_wr && (reg_addr == RDA_ADDR_WEEKLY_HOUR);
  wire wr_wk_days = reg_wr && (reg_addr == RDA_ADDR_WEEKLY_DAYS);
  wire wr_dy_min  = reg_wr && (reg_addr == RDA_ADDR_DAILY_MIN);
  wire wr_dy_hour = reg_wr && (reg_addr == RDA_ADDR_DAILY_HOUR);

  // hour bit 5 is stored as written; its meaning (meridiem or tens) is the host's mode
  rda_preset_reg #(
    .W (RDA_MIN_W)
  ) u_wk_min (
    .clk       (clk),
    .rst_b     (rst_n_i),
    .wr_en     (wr_wk_min),
    .wdata     (reg_wdata[RDA_MIN_W-1:0]),
    .value_reg (wk_min_reg)
  );

  rda_preset_reg #(
    .W (RDA_HOUR_W)
  ) u_wk_hour (
    .clk       (clk),
    .rst_b     (rst_n_i),
    .wr_en     (wr_wk_hour),
    .wdata     (reg_wdata[RDA_HOUR_W-1:0]),
    .value_reg (wk_hour_reg)
  );

  rda_preset_reg #(
    .W (RDA_DAYS_W)
  ) u_wk_days (
    .clk       (clk),
    .rst_b     (rst_n_i),
    .wr_en     (wr_wk_days),
    .wdata     (reg_wdata[RDA_DAYS_W-1:0]),
    .value_reg (wk_days_reg)
  );

  rda_preset_reg #(
    .W (RDA_MIN_W)
  ) u_dy_min (
    .clk       (clk),
    .rst_b     (rst_n_i),
    .wr_en     (wr_dy_min),
    .wdata     (reg_wdata[RDA_MIN_W-1:0]),
    .value_reg (dy_min_reg)
  );

  rda_preset_reg #(
    .W (RDA_HOUR_W)
  ) u_dy_hour (
    .clk       (clk),
    .rst_b     (rst_n_i),
    .wr_en     (wr_dy_hour),
    .wdata     (reg_wdata[RDA_HOUR_W-1:0]),
    .value_reg (dy_hour_reg)
  );

  // weekday counter: 0..6 then wrap
  assign day_next = day_wr ? day_wdata :
                    (day_tick ? ((day_reg >= RDA_DAY_LAST) ? RDA_DAY_FIRST
                                 : 3'(day_reg + 3'h1)) : day_reg);
  always_ff @(posedge clk or negedge rst_n_i) begin
    if (!rst_n_i) day_reg <= RDA_DAY_FIRST;
    else          day_reg <= day_next;
  end
  assign day_count = day_reg;

  // readback with unused high bits forced to zero
  always_comb begin
    reg_hit   = 1'b1;
    reg_rdata = 8'h00;
    case (reg_addr)
      RDA_ADDR_WEEKLY_MIN:  reg_rdata = {1'b0, wk_min_reg};
      RDA_ADDR_WEEKLY_HOUR: reg_rdata = {2'b00, wk_hour_reg};
      RDA_ADDR_WEEKLY_DAYS: reg_rdata = {1'b0, wk_days_reg};
      RDA_ADDR_DAILY_MIN:   reg_rdata = {1'b0, dy_min_reg};
      RDA_ADDR_DAILY_HOUR:  reg_rdata = {2'b00, dy_hour_reg};
      default:              reg_hit   = 1'b0;
    endcase
  end

  // weekday enable selected by counter value; value 7 never enables
  wire day_enabled = (day_reg <= RDA_DAY_LAST) && wk_days_reg[day_reg];
  // 12/24 codes compare raw, so 12 and 32 match the counter's own coding
  wire wk_time_eq = (cur_min == wk_min_reg) && (cur_hour == wk_hour_reg);
  wire dy_time_eq = (cur_min == dy_min_reg) && (cur_hour == dy_hour_reg);
  assign weekly_match = rst_n_i && wk_time_eq && day_enabled;
  assign daily_match  = rst_n_i && dy_time_eq;

  a_mask_silences: assert property (@(posedge clk) disable iff (!rst_n_i)
    (wk_days_reg == 7'h00) |-> !weekly_match) else $error("weekly alarm with empty mask");
  a_weekly_hit: assert property (@(posedge clk) disable iff (!rst_n_i)
    weekly_match |-> (cur_min == wk_min_reg && cur_hour == wk_hour_reg && wk_days_reg[day_count]))
    else $error("weekly match without cause");
  a_daily_exact: assert property (@(posedge clk) disable iff (!rst_n_i)
    daily_match == (cur_min == dy_min_reg && cur_hour == dy_hour_reg)) else $error("daily match wrong");
  a_day_wrap: assert property (@(posedge clk) disable iff (!rst_n_i)
    (day_tick && !day_wr && day_count == 3'h6) |=> (day_count == 3'h0)) else $error("weekday wrap wrong");
  a_day_step: assert property (@(posedge clk) disable iff (!rst_n_i)
    (day_tick && !day_wr && day_count < 3'h6) |=> (day_count == $past(day_count) + 3'h1))
    else $error("weekday step wrong");
  a_min_store: assert property (@(posedge clk) disable iff (!rst_n_i)
    (reg_wr && reg_addr == 4'h8) ##1 (reg_addr == 4'h8) |-> (reg_rdata == {1'b0, $past(reg_wdata[6:0])}))
    else $error("weekly minute readback wrong");
  a_hour_store: assert property (@(posedge clk) disable iff (!rst_n_i)
    (reg_wr && reg_addr == 4'hc) ##1 (reg_addr == 4'hc) |-> (reg_rdata == {2'b00, $past(reg_wdata[5:0])}))
    else $error("daily hour readback wrong");
  a_high_zero: assert property (@(posedge clk) disable iff (!rst_n_i)
    (reg_addr == 4'h9 || reg_addr == 4'hc) |-> (reg_rdata[7:6] == 2'b00)) else $error("hour high bits set");
  a_mask_zero: assert property (@(posedge clk) disable iff (!rst_n_i)
    (reg_addr inside {4'h8, 4'ha, 4'hb}) |-> !reg_rdata[7]) else $error("bit 7 set");
  a_wk_hour_store: assert property (@(posedge clk) disable iff (!rst_n_i)
    (reg_wr && reg_addr == 4'h9) ##1 (reg_addr == 4'h9) |-> (reg_rdata == {2'b00, $past(reg_wdata[5:0])}))
    else $error("weekly hour readback wrong");
  a_days_store: assert property (@(posedge clk) disable iff (!rst_n_i)
    (reg_wr && reg_addr == 4'ha) ##1 (reg_addr == 4'ha) |-> (reg_rdata == {1'b0, $past(reg_wdata[6:0])}))
    else $error("weekday mask readback wrong");
  a_dy_min_store: assert property (@(posedge clk) disable iff (!rst_n_i)
    (reg_wr && reg_addr == 4'hb) ##1 (reg_addr == 4'hb) |-> (reg_rdata == {1'b0, $past(reg_wdata[6:0])}))
    else $error("daily minute readback wrong");
  a_meridiem_kept: assert property (@(posedge clk) disable iff (!rst_n_i)
    (reg_wr && reg_addr == 4'hc) ##1 (reg_addr == 4'hc) |-> (reg_rdata[5] == $past(reg_wdata[5])))
    else $error("daily hour bit 5 lost");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n_i)
    !(reg_addr inside {[4'h8:4'hc]}) |-> (reg_rdata == 8'h00 && !reg_hit))
    else $error("unmapped address answered");
  a_hit_decode: assert property (@(posedge clk) disable iff (!rst_n_i)
    (reg_addr inside {[4'h8:4'hc]}) |-> reg_hit)
    else $error("alarm register not decoded");
  a_day_load: assert property (@(posedge clk) disable iff (!rst_n_i)
    day_wr |=> (day_count == $past(day_wdata)))
    else $error("weekday load wrong");
  a_day_hold: assert property (@(posedge clk) disable iff (!rst_n_i)
    (!day_wr && !day_tick) |=> $stable(day_count))
    else $error("weekday moved without tick");
  a_day_range: assert property (@(posedge clk) disable iff (!rst_n_i)
    (day_tick && !day_wr) |=> (day_count <= 3'h6))
    else $error("weekday stepped out of range");
  a_weekly_exact: assert property (@(posedge clk) disable iff (!rst_n_i)
    weekly_match == (cur_min == wk_min_reg && cur_hour == wk_hour_reg && day_count <= 3'h6
                     && wk_days_reg[day_count]))
    else $error("weekly match wrong");
  a_day7_quiet: assert property (@(posedge clk) disable iff (!rst_n_i)
    (day_count == 3'h7) |-> !weekly_match)
    else $error("weekly match on weekday 7");
  a_noon_code: assert property (@(posedge clk) disable iff (!rst_n_i)
    (cur_hour == 6'h32 && wk_hour_reg == 6'h32 && cur_min == wk_min_reg && day_count <= 3'h6
     && wk_days_reg[day_count]) |-> weekly_match)
    else $error("noon code not matched");
  a_reset_quiet: assert property (@(posedge clk)
    !rst_n_i |-> (!weekly_match && !daily_match && reg_rdata == 8'h00))
    else $error("activity during reset");
endmodule : rda_alarm_regs

// one preset register; contents after power-up carry no meaning
module rda_preset_reg #(
  parameter int W = 7
) (
  input  wire logic         clk,       // clock
  input  wire logic         rst_b,     // async active-low reset
  input  wire logic         wr_en,     // load strobe
  input  wire logic [W-1:0] wdata,     // load value
  output logic      [W-1:0] value_reg  // stored preset
);
  import rda_pkg::*;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      value_reg <= RDA_PRESET_RST[W-1:0];
    end else if (wr_en) begin
      value_reg <= wdata;
    end
  end
endmodule : rda_preset_reg
`default_nettype wire

// ---- rda_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module rda_host (
  input  wire logic       clk,               // register port clock
  output logic      [3:0] reg_addr = 4'h0,   // register address
  output logic            reg_wr = 1'b0,     // write strobe
  output logic      [7:0] reg_wdata = 8'h00  // write data
);
  // one byte per strobe; which weekday a mask bit means is up to the caller
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    @(posedge clk);
    #1;
  endtask : rd
endmodule : rda_host
`default_nettype wire

// ---- test_rda_alarm_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_rda_alarm_regs;
  import rda_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, day_tick = 1'b0, day_wr = 1'b0;
  logic reg_wr, reg_hit, weekly_match, daily_match;
  logic [3:0] reg_addr, a;
  logic [7:0] reg_wdata, reg_rdata;
  logic [6:0] cur_min = 7'h00;
  logic [5:0] cur_hour = 6'h00;
  logic [2:0] day_wdata = 3'h0, day_count;
  logic [31:0] lfsr = 32'h7d1d47e6;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  rda_host host (.clk, .reg_addr, .reg_wr, .reg_wdata);
  rda_alarm_regs dut (.clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .reg_hit, .cur_min,
    .cur_hour, .day_tick, .day_wr, .day_wdata, .day_count, .weekly_match, .daily_match);
  initial begin
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  function automatic logic [7:0] kept(input logic [3:0] ad, input logic [7:0] d);
    return (ad == RDA_ADDR_WEEKLY_HOUR || ad == RDA_ADDR_DAILY_HOUR) ? {2'h0, d[5:0]} : {1'h0, d[6:0]};
  endfunction : kept
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 20; i++) begin
      lfsr = nx(lfsr);
      a = 4'h8 + 4'(i % 5);
      host.wr(a, lfsr[7:0]);
      host.rd(a);
      chk(reg_rdata, kept(a, lfsr[7:0]));
      chk({7'h0, reg_hit}, 8'h01);
    end
    host.rd(4'h3);
    chk({reg_hit, reg_rdata[6:0]}, 8'h00);
    $display("register test done");
    host.wr(RDA_ADDR_WEEKLY_MIN, 8'h30);
    host.wr(RDA_ADDR_WEEKLY_HOUR, 8'h32);
    host.wr(RDA_ADDR_DAILY_MIN, 8'h30);
    host.wr(RDA_ADDR_DAILY_HOUR, 8'h12);
    cur_min <= 7'h30;
    cur_hour <= 6'h32;
    for (int k = 0; k < 7; k++) begin
      day_wr <= 1'b1;
      day_wdata <= 3'(k);
      host.wr(RDA_ADDR_WEEKLY_DAYS, 8'h01 << k);
      day_wr <= 1'b0;
      host.rd(RDA_ADDR_WEEKLY_DAYS);
      chk({6'h0, weekly_match, daily_match}, 8'h02);
      host.wr(RDA_ADDR_WEEKLY_DAYS, ~(8'h01 << k));
      host.rd(RDA_ADDR_WEEKLY_DAYS);
      chk({7'h0, weekly_match}, 8'h00);
    end
    $display("weekday test done");
    host.wr(RDA_ADDR_WEEKLY_DAYS, 8'h00);
    cur_hour <= 6'h12;
    host.rd(RDA_ADDR_WEEKLY_DAYS);
    chk({6'h0, weekly_match, daily_match}, 8'h01);
    cur_min <= 7'h31;
    host.rd(RDA_ADDR_DAILY_MIN);
    chk({7'h0, daily_match}, 8'h00);
    day_wr <= 1'b1;
    day_wdata <= RDA_DAY_LAST;
    @(posedge clk);
    day_wr <= 1'b0;
    day_tick <= 1'b1;
    @(posedge clk);
    day_tick <= 1'b0;
    #1;
    chk({5'h0, day_count}, {5'h0, RDA_DAY_FIRST});
    $display("match and counter test done");
    summarize();
  end
endmodule : test_rda_alarm_regs
`default_nettype wire
